// ==== afz_pkg.sv ====
package afz_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] AFZ_ADDR_CH1_MIN = 8'h64;
    localparam logic [7:0] AFZ_ADDR_CH2_MIN = 8'h65;
    localparam logic [7:0] AFZ_ADDR_CH3_MIN = 8'h66;
    localparam logic [7:0] AFZ_ADDR_Z1_LOW = 8'h67;
    localparam logic [7:0] AFZ_ADDR_Z2_LOW = 8'h68;
    localparam logic [7:0] AFZ_ADDR_Z3_LOW = 8'h69;
    localparam logic [7:0] AFZ_ADDR_Z1_ABS = 8'h6A;
    localparam logic [7:0] AFZ_ADDR_Z2_ABS = 8'h6B;
    localparam logic [7:0] AFZ_ADDR_Z3_ABS = 8'h6C;
    localparam logic [7:0] AFZ_ADDR_Z12_HYS = 8'h6D;
    localparam logic [7:0] AFZ_ADDR_Z3_HYS = 8'h6E;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] AFZ_RST_MIN = 8'h80;
    localparam logic [7:0] AFZ_RST_LOW = 8'h5A;
    localparam logic [7:0] AFZ_RST_ABS = 8'h64;
    localparam logic [7:0] AFZ_RST_Z12_HYS = 8'h44;
    localparam logic [7:0] AFZ_RST_Z3_HYS = 8'h40;

    // ------------------------------------------------------------
    // field layout and special codes
    // ------------------------------------------------------------
    localparam int AFZ_HYS_HI_LSB = 4;
    localparam int AFZ_HYS_LO_LSB = 0;
    localparam int AFZ_HYS_W = 4;
    localparam logic [7:0] AFZ_ABS_DISABLE = 8'h80;
    localparam logic [7:0] AFZ_DUTY_FULL = 8'hFF;
    localparam logic [7:0] AFZ_DUTY_OFF = 8'h00;
    localparam logic [7:0] AFZ_PWM_TOP = 8'hFE;

    // fan channel operating mode as seen by this block
    typedef enum logic [1:0] {
        AFZ_MODE_AUTO,
        AFZ_MODE_MANUAL,
        AFZ_MODE_DISABLED,
        AFZ_MODE_SPARE
    } afz_mode_type;
endpackage

// ==== afz_zone_eval.sv ====
`timescale 1ns/1ps
`default_nettype none
module afz_zone_eval
    import afz_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic temp_update,
    input wire logic [7:0] temp,
    input wire logic [7:0] low_limit,
    input wire logic [7:0] abs_limit,
    input wire logic [3:0] margin,
    output logic at_or_above_low,
    output logic fan_held_on,
    output logic abs_trip
);
    logic signed [8:0] temp_s;
    logic signed [8:0] low_s;
    logic signed [8:0] off_point;

    // signed compares, widened so low minus margin cannot wrap
    assign temp_s = {temp[7], temp};
    assign low_s = {low_limit[7], low_limit};
    assign off_point = low_s - $signed({5'h00, margin});

    // ------------------------------------------------------------
    // latched comparison results, refreshed on each new reading
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            at_or_above_low <= 1'b0;
            abs_trip <= 1'b0;
        end else if (temp_update) begin
            at_or_above_low <= (temp_s >= low_s);
            // 80h switches the override off for this zone
            abs_trip <= (abs_limit != AFZ_ABS_DISABLE) &&
                        (temp_s > $signed({abs_limit[7], abs_limit}));
        end
    end

    // on at the low limit, off only below low limit minus margin
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fan_held_on <= 1'b0;
        end else if (temp_update) begin
            if (temp_s >= low_s) begin
                fan_held_on <= 1'b1;
            end else if (temp_s < off_point) begin
                fan_held_on <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== afz_pwm_out.sv ====
`timescale 1ns/1ps
`default_nettype none
module afz_pwm_out
    import afz_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] duty,
    output logic pwm_pin
);
    logic [7:0] phase_r;

    // period of 255 steps so that FFh is always high and 00h always low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_r <= 8'h00;
        end else if (phase_r == AFZ_PWM_TOP) begin
            phase_r <= 8'h00;
        end else begin
            phase_r <= phase_r + 8'h01;
        end
    end

    // duty/255 high time
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwm_pin <= 1'b0;
        end else begin
            pwm_pin <= (phase_r < duty);
        end
    end
endmodule
`default_nettype wire

// ==== afz_fan_limits.sv ====
`timescale 1ns/1ps
`default_nettype none
module afz_fan_limits
    import afz_pkg::*;
#(
    parameter int NUM_CH = 3
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic lock,
    input wire logic temp_update,
    input wire logic [7:0] zone1_temp,
    input wire logic [7:0] zone2_temp,
    input wire logic [7:0] zone3_temp,
    input wire logic [3:0] zone1_range,
    input wire logic [3:0] zone2_range,
    input wire logic [3:0] zone3_range,
    input wire logic [5:0] chan_zone_sel,
    input wire logic [5:0] chan_mode,
    input wire logic [2:0] below_limit_select,
    input wire logic [7:0] manual_duty_ch1,
    input wire logic [7:0] manual_duty_ch2,
    input wire logic [7:0] manual_duty_ch3,
    output logic [7:0] duty_ch1,
    output logic [7:0] duty_ch2,
    output logic [7:0] duty_ch3,
    output logic override_active,
    output logic fan_channel_1,
    output logic fan_channel_2,
    output logic fan_channel_3
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // whole degrees at which the ramp reaches full; fractional ranges round up
    function automatic logic [7:0] range_degrees(input logic [3:0] code);
        logic [7:0] deg;
        deg = 8'h20;
        case (code)
            4'h0: deg = 8'h02;
            4'h1: deg = 8'h03;
            4'h2: deg = 8'h04;
            4'h3: deg = 8'h04;
            4'h4: deg = 8'h05;
            4'h5: deg = 8'h07;
            4'h6: deg = 8'h08;
            4'h7: deg = 8'h0A;
            4'h8: deg = 8'h0E;
            4'h9: deg = 8'h10;
            4'hA: deg = 8'h14;
            4'hB: deg = 8'h1B;
            4'hC: deg = 8'h20;
            4'hD: deg = 8'h28;
            4'hE: deg = 8'h36;
            4'hF: deg = 8'h50;
            default: deg = 8'h20;
        endcase
        return deg;
    endfunction

    // two-bit field of one channel, channel 1 in the low bits
    function automatic logic [1:0] chan_field(input logic [5:0] vec, input int c);
        return vec[2*c +: 2];
    endfunction

    // linear ramp from minimum at the limit to full at limit plus span
    function automatic logic [7:0] ramp_duty(
        input logic [7:0] min_duty,
        input logic [7:0] above,
        input logic [7:0] span
    );
        logic [15:0] prod;
        logic [15:0] step;
        prod = 16'h0000;
        step = 16'h0000;
        if (above >= span) begin
            return AFZ_DUTY_FULL;
        end
        prod = 16'(AFZ_DUTY_FULL - min_duty) * 16'(above);
        step = prod / 16'(span);
        return 8'(16'(min_duty) + step);
    endfunction

    // ------------------------------------------------------------
    // lockable registers
    // ------------------------------------------------------------
    logic [7:0] min_duty_r [NUM_CH];
    logic [7:0] low_limit_r [NUM_CH];
    logic [7:0] abs_limit_r [NUM_CH];
    logic [7:0] zone12_margin_r;
    logic [3:0] zone3_margin_r;
    logic wr_ok;

    assign wr_ok = reg_wr && !lock;

    // minimum duty per channel
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                min_duty_r[i] <= AFZ_RST_MIN;
            end
        end else if (wr_ok) begin
            case (reg_addr)
                AFZ_ADDR_CH1_MIN: min_duty_r[0] <= reg_wdata;
                AFZ_ADDR_CH2_MIN: min_duty_r[1] <= reg_wdata;
                AFZ_ADDR_CH3_MIN: min_duty_r[2] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // zone limits; the comparisons pick up a new limit at the next reading, the ramp offset at the write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                low_limit_r[i] <= AFZ_RST_LOW;
                abs_limit_r[i] <= AFZ_RST_ABS;
            end
        end else if (wr_ok) begin
            case (reg_addr)
                AFZ_ADDR_Z1_LOW: low_limit_r[0] <= reg_wdata;
                AFZ_ADDR_Z2_LOW: low_limit_r[1] <= reg_wdata;
                AFZ_ADDR_Z3_LOW: low_limit_r[2] <= reg_wdata;
                AFZ_ADDR_Z1_ABS: abs_limit_r[0] <= reg_wdata;
                AFZ_ADDR_Z2_ABS: abs_limit_r[1] <= reg_wdata;
                AFZ_ADDR_Z3_ABS: abs_limit_r[2] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // turn-off margins
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            zone12_margin_r <= AFZ_RST_Z12_HYS;
            zone3_margin_r <= AFZ_RST_Z3_HYS[AFZ_HYS_HI_LSB +: AFZ_HYS_W];
        end else if (wr_ok) begin
            case (reg_addr)
                AFZ_ADDR_Z12_HYS: zone12_margin_r <= reg_wdata;
                // low nibble is reserved and not stored
                AFZ_ADDR_Z3_HYS: zone3_margin_r <= reg_wdata[AFZ_HYS_HI_LSB +: AFZ_HYS_W];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    logic rd_mapped;

    always_comb begin
        rd_mux = 8'h00;
        rd_mapped = 1'b1;
        case (reg_addr)
            AFZ_ADDR_CH1_MIN: rd_mux = min_duty_r[0];
            AFZ_ADDR_CH2_MIN: rd_mux = min_duty_r[1];
            AFZ_ADDR_CH3_MIN: rd_mux = min_duty_r[2];
            AFZ_ADDR_Z1_LOW: rd_mux = low_limit_r[0];
            AFZ_ADDR_Z2_LOW: rd_mux = low_limit_r[1];
            AFZ_ADDR_Z3_LOW: rd_mux = low_limit_r[2];
            AFZ_ADDR_Z1_ABS: rd_mux = abs_limit_r[0];
            AFZ_ADDR_Z2_ABS: rd_mux = abs_limit_r[1];
            AFZ_ADDR_Z3_ABS: rd_mux = abs_limit_r[2];
            AFZ_ADDR_Z12_HYS: rd_mux = zone12_margin_r;
            AFZ_ADDR_Z3_HYS: rd_mux = {zone3_margin_r, 4'h0};
            default: rd_mapped = 1'b0;
        endcase
    end

    // data is held until the next read; unmapped reads give 00h
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
            reg_hit <= rd_mapped;
        end
    end

    // ------------------------------------------------------------
    // zone evaluation
    // ------------------------------------------------------------
    logic [7:0] zone_temp [NUM_CH];
    logic [3:0] zone_range [NUM_CH];
    logic [3:0] zone_margin [NUM_CH];
    logic [NUM_CH-1:0] zone_at_low;
    logic [NUM_CH-1:0] zone_held;
    logic [NUM_CH-1:0] zone_trip;

    // loose per-zone ports and the margin nibbles gathered into arrays
    assign zone_temp[0] = zone1_temp;
    assign zone_temp[1] = zone2_temp;
    assign zone_temp[2] = zone3_temp;
    assign zone_range[0] = zone1_range;
    assign zone_range[1] = zone2_range;
    assign zone_range[2] = zone3_range;
    assign zone_margin[0] = zone12_margin_r[AFZ_HYS_HI_LSB +: AFZ_HYS_W];
    assign zone_margin[1] = zone12_margin_r[AFZ_HYS_LO_LSB +: AFZ_HYS_W];
    assign zone_margin[2] = zone3_margin_r;

    // one comparator set per zone, all sampled on the same reading strobe
    for (genvar z = 0; z < NUM_CH; z++) begin : g_zone
        afz_zone_eval u_eval (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .temp_update(temp_update),
            .temp(zone_temp[z]),
            .low_limit(low_limit_r[z]),
            .abs_limit(abs_limit_r[z]),
            .margin(zone_margin[z]),
            .at_or_above_low(zone_at_low[z]),
            .fan_held_on(zone_held[z]),
            .abs_trip(zone_trip[z])
        );
    end

    // ------------------------------------------------------------
    // override and per-channel duty
    // ------------------------------------------------------------
    afz_mode_type ch_mode [NUM_CH];
    logic any_auto;
    logic trip_now;
    logic [7:0] manual_duty [NUM_CH];
    logic [7:0] duty_nxt [NUM_CH];

    // manual duty as an array for the channel loop
    assign manual_duty[0] = manual_duty_ch1;
    assign manual_duty[1] = manual_duty_ch2;
    assign manual_duty[2] = manual_duty_ch3;

    always_comb begin
        any_auto = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            ch_mode[c] = afz_mode_type'(chan_field(chan_mode, c));
            if (ch_mode[c] == AFZ_MODE_AUTO) begin
                any_auto = 1'b1;
            end
        end
        // any zone counts, tied to a channel or not
        trip_now = any_auto && (|zone_trip);
    end

    // choose each channel's duty; the override outranks everything but the disabled and spare modes
    always_comb begin
        logic [1:0] zsel;
        logic [7:0] above;
        zsel = 2'h0;
        above = 8'h00;
        for (int c = 0; c < NUM_CH; c++) begin
            zsel = chan_field(chan_zone_sel, c);
            if (zsel > 2'(NUM_CH - 1)) begin
                zsel = 2'(NUM_CH - 1);
            end
            above = 8'(zone_temp[zsel] - low_limit_r[zsel]);
            case (ch_mode[c])
                AFZ_MODE_DISABLED: duty_nxt[c] = AFZ_DUTY_OFF;
                AFZ_MODE_MANUAL: duty_nxt[c] = trip_now ? AFZ_DUTY_FULL
                                                        : manual_duty[c];
                AFZ_MODE_AUTO: begin
                    if (trip_now) begin
                        duty_nxt[c] = AFZ_DUTY_FULL;
                    end else if (zone_at_low[zsel]) begin
                        duty_nxt[c] = ramp_duty(min_duty_r[c], above,
                                                range_degrees(zone_range[zsel]));
                    end else if (zone_held[zsel] || below_limit_select[c]) begin
                        duty_nxt[c] = min_duty_r[c];
                    end else begin
                        duty_nxt[c] = AFZ_DUTY_OFF;
                    end
                end
                default: duty_nxt[c] = AFZ_DUTY_OFF;
            endcase
        end
    end

    // registered duty and override flag
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            duty_ch1 <= AFZ_DUTY_OFF;
            duty_ch2 <= AFZ_DUTY_OFF;
            duty_ch3 <= AFZ_DUTY_OFF;
            override_active <= 1'b0;
        end else begin
            duty_ch1 <= duty_nxt[0];
            duty_ch2 <= duty_nxt[1];
            duty_ch3 <= duty_nxt[2];
            override_active <= trip_now;
        end
    end

    // ------------------------------------------------------------
    // pwm pins
    // ------------------------------------------------------------
    afz_pwm_out u_fan_channel_1 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .duty(duty_ch1),
        .pwm_pin(fan_channel_1)
    );

    afz_pwm_out u_pwm2 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .duty(duty_ch2),
        .pwm_pin(fan_channel_2)
    );

    afz_pwm_out u_pwm3 (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .duty(duty_ch3),
        .pwm_pin(fan_channel_3)
    );
endmodule
`default_nettype wire

// ==== afz_fan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module afz_fan_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic drive_pin,
    output logic [7:0] high_len
);
    logic [7:0] run_r;
    logic last_r;
    // a fan only sees the high time of its drive pin; latch each run length
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            run_r <= 8'h00;
            last_r <= 1'b0;
            high_len <= 8'h00;
        end else begin
            last_r <= drive_pin;
            run_r <= drive_pin ? run_r + 8'h01 : 8'h00;
            if (last_r && !drive_pin) begin
                high_len <= run_r;
            end
        end
    end
endmodule
`default_nettype wire

// ==== afz_fan_limits_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module afz_fan_limits_checker
    import afz_pkg::*;
#(
    parameter int NUM_CH = 3
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire logic lock,
    input wire logic temp_update,
    input wire logic [7:0] zone1_temp,
    input wire logic [5:0] chan_mode,
    input wire logic [5:0] chan_zone_sel,
    input wire logic [7:0] manual_duty_ch2,
    input wire logic [7:0] duty_ch1,
    input wire logic [7:0] duty_ch2,
    input wire logic [7:0] duty_ch3,
    input wire logic override_active,
    input wire logic fan_channel_1
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] low1_r;
    logic [7:0] min1_r;
    // shadows of two registers; the block exposes their contents only through register reads
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            low1_r <= AFZ_RST_LOW;
            min1_r <= AFZ_RST_MIN;
        end else if (reg_wr && !lock) begin
            if (reg_addr == AFZ_ADDR_Z1_LOW) low1_r <= reg_wdata;
            if (reg_addr == AFZ_ADDR_CH1_MIN) min1_r <= reg_wdata;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_disabled_off;
        chan_mode[5:4] == 2'h2 |=> duty_ch3 == 8'h00;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("disabled channel not at zero duty");
    property p_override_full;
        override_active && $past(chan_mode[1:0]) == 2'h0 |-> duty_ch1 == AFZ_DUTY_FULL;
    endproperty
    a_override_full: assert property (p_override_full)
        else $error("auto channel not full during override");
    property p_manual_duty;
        chan_mode[3:2] == 2'h1 |=>
            duty_ch2 == (override_active ? AFZ_DUTY_FULL : $past(manual_duty_ch2));
    endproperty
    a_manual_duty: assert property (p_manual_duty)
        else $error("manual channel duty wrong");
    property p_no_auto_no_trip;
        (chan_mode[1:0] != 2'h0 && chan_mode[3:2] != 2'h0 && chan_mode[5:4] != 2'h0)
            |=> !override_active;
    endproperty
    a_no_auto_no_trip: assert property (p_no_auto_no_trip)
        else $error("override without any auto channel");
    property p_pin_full;
        duty_ch1 == 8'hFF |=> fan_channel_1;
    endproperty
    a_pin_full: assert property (p_pin_full)
        else $error("pin low at full duty");
    property p_pin_off;
        duty_ch1 == 8'h00 |=> !fan_channel_1;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin high at zero duty");
    property p_lock_hold;
        (reg_rd && (lock || !reg_wr)) ##1 (reg_rd && lock && $stable(reg_addr))
            |=> $stable(reg_rdata);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked register changed");
    property p_margin_nibble;
        reg_rd && reg_addr == AFZ_ADDR_Z3_HYS |=> reg_rdata[3:0] == 4'h0 && reg_hit;
    endproperty
    a_margin_nibble: assert property (p_margin_nibble)
        else $error("reserved nibble not zero");
    property p_on_at_low;
        (temp_update && zone1_temp == low1_r && chan_mode[1:0] == 2'h0
            && chan_zone_sel[1:0] == 2'h0)
        ##1 (!temp_update && !reg_wr && $stable(chan_mode) && $stable(chan_zone_sel))
        |=> override_active || duty_ch1 == min1_r;
    endproperty
    a_on_at_low: assert property (p_on_at_low)
        else $error("fan not at minimum at low limit");
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
    import afz_pkg::*;
;
    logic sys_clk, sys_rst, reg_wr, reg_rd, lock, temp_update;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, zone1_temp, zone2_temp, zone3_temp;
    logic [7:0] manual_duty_ch1, manual_duty_ch2, manual_duty_ch3;
    logic [7:0] duty_ch1, duty_ch2, duty_ch3, fan_high_len, rd_val;
    logic [3:0] zone1_range, zone2_range, zone3_range;
    logic [5:0] chan_mode, chan_zone_sel;
    logic [2:0] below_limit_select;
    logic reg_hit, override_active, fan_channel_1, fan_channel_2, fan_channel_3;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    afz_fan_limits #(.NUM_CH(3)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .lock(lock), .temp_update(temp_update), .zone1_temp(zone1_temp),
        .zone2_temp(zone2_temp), .zone3_temp(zone3_temp), .zone1_range(zone1_range),
        .zone2_range(zone2_range), .zone3_range(zone3_range), .chan_zone_sel(chan_zone_sel),
        .chan_mode(chan_mode), .below_limit_select(below_limit_select),
        .manual_duty_ch1(manual_duty_ch1), .manual_duty_ch2(manual_duty_ch2),
        .manual_duty_ch3(manual_duty_ch3), .duty_ch1(duty_ch1), .duty_ch2(duty_ch2),
        .duty_ch3(duty_ch3), .override_active(override_active),
        .fan_channel_1(fan_channel_1), .fan_channel_2(fan_channel_2),
        .fan_channel_3(fan_channel_3));
    afz_fan_model u_fan (.sys_clk(sys_clk), .sys_rst(sys_rst), .drive_pin(fan_channel_1),
        .high_len(fan_high_len));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    // new readings, then wait past the two-cycle answer before comparing
    task automatic step(input logic [7:0] t1, input logic [7:0] t3, input logic [7:0] e1);
        @(posedge sys_clk);
        temp_update <= 1'b1;
        zone1_temp <= t1;
        zone3_temp <= t3;
        @(posedge sys_clk);
        temp_update <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(duty_ch1, e1);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reg_defaults();
        logic [7:0] exp [11] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A,
            8'h64, 8'h64, 8'h64, 8'h44, 8'h40};
        for (int i = 0; i < 11; i++) begin
            rd(8'h64 + 8'(i));
            chk(rd_val, exp[i]);
        end
        rd(8'h6F);
        chk({7'h00, reg_hit}, 8'h00);
    endtask
    task automatic t_lock();
        @(posedge sys_clk);
        lock <= 1'b1;
        for (int i = 0; i < 11; i++) wr(8'h64 + 8'(i), 8'hFF);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= AFZ_ADDR_Z1_LOW;
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_wdata <= 8'h00;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        chk(reg_rdata, 8'h5A);
        t_reg_defaults();
        @(posedge sys_clk);
        lock <= 1'b0;
    endtask
    task automatic t_zone1();
        wr(AFZ_ADDR_Z1_LOW, 8'h32);
        wr(AFZ_ADDR_Z12_HYS, 8'h54);
        step(8'h31, 8'h00, 8'h00);
        step(8'h32, 8'h00, 8'h80);
        step(8'h36, 8'h00, 8'hBF);
        step(8'h3A, 8'h00, 8'hFF);
        step(8'h31, 8'h00, 8'h80);
        step(8'h2D, 8'h00, 8'h80);
        step(8'h2C, 8'h00, 8'h00);
        @(posedge sys_clk);
        below_limit_select <= 3'h1;
        chan_mode <= 6'h34;
        repeat (600) @(posedge sys_clk);
        #1;
        chk(duty_ch1, 8'h80);
        chk(fan_high_len, 8'h80);
        chk(duty_ch2, 8'h33);
        chk(duty_ch3, 8'h00);
        chk({7'h00, fan_channel_3}, 8'h00);
        @(posedge sys_clk);
        below_limit_select <= 3'h0;
        chan_mode <= 6'h24;
    endtask
    task automatic t_signed();
        wr(AFZ_ADDR_Z1_LOW, 8'hCE);
        step(8'hCE, 8'h00, 8'h80);
        step(8'hCD, 8'h00, 8'h80);
        step(8'hC8, 8'h00, 8'h00);
        step(8'h00, 8'h00, 8'hFF);
    endtask
    task automatic t_override();
        wr(AFZ_ADDR_Z3_ABS, 8'h10);
        step(8'hC0, 8'h11, 8'hFF);
        chk(duty_ch2, 8'hFF);
        chk({7'h00, fan_channel_2}, 8'h01);
        chk(duty_ch3, 8'h00);
        chk({7'h00, override_active}, 8'h01);
        step(8'hC0, 8'h10, 8'h00);
        wr(AFZ_ADDR_Z3_ABS, AFZ_ABS_DISABLE);
        step(8'hC0, 8'h7F, 8'h00);
        step(8'hC0, 8'h81, 8'h00);
        // unassigned zone parked at the top code
        wr(AFZ_ADDR_Z3_ABS, 8'h7F);
        step(8'hC0, 8'h7F, 8'h00);
        wr(AFZ_ADDR_Z3_ABS, 8'h10);
        @(posedge sys_clk);
        chan_mode <= 6'h25;
        step(8'hC0, 8'h11, 8'h22);
        chk({7'h00, override_active}, 8'h00);
        wr(AFZ_ADDR_Z3_ABS, AFZ_RST_ABS);
        @(posedge sys_clk);
        chan_mode <= 6'h24;
    endtask
    task automatic t_regs_rw();
        wr(8'h6F, 8'hFF);
        for (int i = 0; i < 11; i++) wr(8'h64 + 8'(i), 8'h3C + 8'(i));
        for (int i = 0; i < 11; i++) begin
            rd(8'h64 + 8'(i));
            chk(rd_val, (i == 10) ? 8'h40 : 8'h3C + 8'(i));
        end
        rd(8'h6F);
        chk(rd_val, 8'h00);
    endtask
    // hang guard well above the expected run of under a thousand cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, lock, temp_update} = 4'h0;
        {reg_addr, reg_wdata, zone1_temp, zone2_temp, zone3_temp} = '0;
        {zone1_range, zone2_range, zone3_range} = {4'h6, 4'h0, 4'h0};
        chan_mode = 6'h24;
        chan_zone_sel = 6'h14;
        below_limit_select = 3'h0;
        {manual_duty_ch1, manual_duty_ch2, manual_duty_ch3} = {8'h22, 8'h33, 8'h00};
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reg_defaults();
        t_lock();
        t_zone1();
        t_signed();
        t_override();
        t_regs_rw();
        print_verdict();
    end
endmodule
bind afz_fan_limits afz_fan_limits_checker #(.NUM_CH(NUM_CH)) u_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .lock(lock), .temp_update(temp_update), .zone1_temp(zone1_temp), .chan_mode(chan_mode),
    .chan_zone_sel(chan_zone_sel), .manual_duty_ch2(manual_duty_ch2), .duty_ch1(duty_ch1),
    .duty_ch2(duty_ch2), .duty_ch3(duty_ch3), .override_active(override_active),
    .fan_channel_1(fan_channel_1));
`default_nettype wire
